// ---- bsl_pkg.sv ----
// constants and types shared by the boot stream loader files
`default_nettype none
package bsl_pkg;
	localparam logic [15:0] BSL_KEY_8BIT = 16'h08AA; // width key, byte stream
	localparam logic [15:0] BSL_KEY_16BIT = 16'h10AA; // width key, word stream
	localparam logic [7:0] BSL_KEY_LOW_BYTE = 8'hAA; // low byte common to both keys
	localparam logic [2:0] BSL_RSVD_LAST = 3'h7; // index of the eighth discarded word
	localparam logic [15:0] BSL_END_SIZE = 16'h0000; // block length that ends the load
	localparam int BSL_ENTRY_W = 23; // entry field spans bits 22 down to 0
	localparam int BSL_ENTRY_HI_W = 7; // bits 22..16 carried by word ten
	localparam int BSL_ADDR_W = 32; // destination address width
	localparam logic [BSL_ADDR_W-1:0] BSL_ADDR_ONE = 32'h0000_0001; // address step per word
	localparam logic [15:0] BSL_WORD_RST = 16'h0000; // reset value of word registers
	// loader states, gray coded from idle through data; key to abort, data to size and size to done are not
	typedef enum logic [3:0] {
		BSL_IDLE = 4'h0,
		BSL_KEY = 4'h1,
		BSL_RSVD = 4'h3,
		BSL_ENT_HI = 4'h2,
		BSL_ENT_LO = 4'h6,
		BSL_SIZE = 4'h7,
		BSL_ADR_HI = 4'h5,
		BSL_ADR_LO = 4'h4,
		BSL_DATA = 4'hC,
		BSL_DONE = 4'hD,
		BSL_ABORT = 4'hF
	} bsl_state_e;
endpackage
`default_nettype wire

// ---- bsl_word_if.sv ----
// carrier between the loader and its word assembler
`default_nettype none
interface bsl_word_if;
	logic restart; // pulse: new load, forget width and half bytes
	logic raw_valid; // one raw transfer from the host port
	logic [15:0] raw_data; // raw transfer, bytes on bits 7..0
	logic word_valid; // pulse: one assembled 16-bit word
	logic [15:0] word_data; // assembled word
	logic wide; // stream width is 16 bits
	modport loader (output restart, output raw_valid, output raw_data,
		input word_valid, input word_data, input wide);
	modport packer (input restart, input raw_valid, input raw_data,
		output word_valid, output word_data, output wide);
endinterface
`default_nettype wire

// ---- bsl_word_pack.sv ----
// word assembler: detects stream width and pairs bytes into words
`default_nettype none
module bsl_word_pack (
	input wire logic clock,
	input wire logic reset_n,
	bsl_word_if.packer wif
);
	logic seen_reg; // first transfer of the load already taken
	logic wide_reg; // 16-bit stream
	logic low_pend_reg; // low byte held, waiting for high byte
	logic [7:0] low_byte_reg; // held low byte
	logic word_valid_reg; // word strobe
	logic [15:0] word_data_reg; // word out

	assign wif.word_valid = word_valid_reg;
	assign wif.word_data = word_data_reg;
	assign wif.wide = wide_reg;

	// width detection from the first transfer; an unknown value is passed on whole
	// so the loader can refuse it as a key
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			seen_reg <= 1'b0;
			wide_reg <= 1'b0;
		end else if (wif.restart) begin
			seen_reg <= 1'b0;
			wide_reg <= 1'b0;
		end else if (wif.raw_valid && !seen_reg) begin
			seen_reg <= 1'b1;
			wide_reg <= (wif.raw_data == bsl_pkg::BSL_KEY_16BIT);
		end
	end

	// byte pairing, low byte first; see R10
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_pend_reg <= 1'b0;
			low_byte_reg <= 8'h00;
			word_valid_reg <= 1'b0;
			word_data_reg <= bsl_pkg::BSL_WORD_RST;
		end else begin
			word_valid_reg <= 1'b0;
			if (wif.restart) begin
				low_pend_reg <= 1'b0;
			end else if (wif.raw_valid) begin
				if (!seen_reg) begin
					// full 16-bit key, or a byte key low half, or garbage
					if (wif.raw_data != bsl_pkg::BSL_KEY_16BIT &&
						wif.raw_data[7:0] == bsl_pkg::BSL_KEY_LOW_BYTE &&
						wif.raw_data[15:8] == 8'h00) begin
						low_pend_reg <= 1'b1;
						low_byte_reg <= wif.raw_data[7:0];
					end else begin
						word_valid_reg <= 1'b1;
						word_data_reg <= wif.raw_data;
					end
				end else if (wide_reg) begin
					word_valid_reg <= 1'b1;
					word_data_reg <= wif.raw_data;
				end else if (!low_pend_reg) begin
					low_pend_reg <= 1'b1;
					low_byte_reg <= wif.raw_data[7:0];
				end else begin
					low_pend_reg <= 1'b0;
					word_valid_reg <= 1'b1;
					word_data_reg <= {wif.raw_data[7:0], low_byte_reg};
				end
			end
		end
	end

	// second byte lands above the first one
	property p_byte_pair;
		@(posedge clock) disable iff (!reset_n)
		(wif.raw_valid && seen_reg && !wide_reg && low_pend_reg && !wif.restart)
		|=> (word_valid_reg && word_data_reg[15:8] == $past(wif.raw_data[7:0]) &&
			word_data_reg[7:0] == $past(low_byte_reg));
	endproperty
	a_byte_pair: assert property (p_byte_pair) else $error("byte pair misassembled"); // see R10
endmodule
`default_nettype wire

// ---- bsl_loader.sv ----
// boot stream loader: parses key, header and blocks, writes block words to memory
// Contract
// R1 - first word is width key, 08AA or 10AA
// R2 - bad key aborts; nothing more stored
// R3 - eight following words read and dropped
// R4 - words ten, eleven give entry address
// R5 - on end, hand entry address to caller
// R6 - block length counts 16-bit words
// R7 - destination address follows length, high word first
// R8 - exactly length data words stored per block
// R9 - zero length ends load, nothing follows
// R10 - byte stream low byte first, high word first
// R11 - block words go to successive addresses
// R12 - error flag on abort, done flag on end
`default_nettype none
module bsl_loader (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	input wire logic in_valid,
	input wire logic [15:0] in_data,
	output logic load_busy,
	output logic load_done,
	output logic load_error,
	output logic stream_wide,
	output logic entry_valid,
	output logic [bsl_pkg::BSL_ENTRY_W-1:0] entry_addr,
	output logic mem_we,
	output logic [bsl_pkg::BSL_ADDR_W-1:0] mem_addr,
	output logic [15:0] mem_wdata
);
	bsl_word_if wif (); // carrier to the assembler
	bsl_pkg::bsl_state_e state_reg; // parser state
	logic busy_reg; // load in progress
	logic done_reg; // load ended normally
	logic error_reg; // load aborted on key
	logic [2:0] rsvd_cnt_reg; // discarded header words so far
	logic [bsl_pkg::BSL_ENTRY_HI_W-1:0] entry_hi_reg; // entry bits 22..16
	logic [bsl_pkg::BSL_ENTRY_W-1:0] entry_reg; // captured entry address
	logic entry_valid_reg; // entry handed to caller
	logic [15:0] left_reg; // words still due in this block
	logic [15:0] addr_hi_reg; // destination bits 31..16
	logic [bsl_pkg::BSL_ADDR_W-1:0] wr_addr_reg; // next write address
	logic mem_we_reg; // memory write strobe
	logic [bsl_pkg::BSL_ADDR_W-1:0] mem_addr_reg; // write address out
	logic [15:0] mem_wdata_reg; // write data out
	logic launch; // start accepted
	logic wv; // assembled word present
	logic [15:0] wd; // assembled word

	// only a recognised width key may open the load
	function automatic logic key_ok(input logic [15:0] w);
		key_ok = (w == bsl_pkg::BSL_KEY_8BIT) || (w == bsl_pkg::BSL_KEY_16BIT);
	endfunction

	// start while busy is ignored so a running load cannot be corrupted
	assign launch = start && !busy_reg;
	assign wv = wif.word_valid;
	assign wd = wif.word_data;
	assign wif.restart = launch;
	// raw transfers only reach the assembler during a load; see R2
	assign wif.raw_valid = in_valid && busy_reg;
	assign wif.raw_data = in_data;

	bsl_word_pack u_pack (
		.clock(clock),
		.reset_n(reset_n),
		.wif(wif)
	);

	assign load_busy = busy_reg;
	assign load_done = done_reg;
	assign load_error = error_reg;
	assign stream_wide = wif.wide;
	assign entry_valid = entry_valid_reg;
	assign entry_addr = entry_reg;
	assign mem_we = mem_we_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;

	// parser state machine
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= bsl_pkg::BSL_IDLE;
		end else if (launch) begin
			state_reg <= bsl_pkg::BSL_KEY;
		end else if (wv) begin
			case (state_reg)
				bsl_pkg::BSL_KEY: begin
					// unknown key: park until the next start; see R1 R2
					state_reg <= key_ok(wd) ? bsl_pkg::BSL_RSVD : bsl_pkg::BSL_ABORT;
				end
				bsl_pkg::BSL_RSVD: begin
					// eighth reserved word read; see R3
					if (rsvd_cnt_reg == bsl_pkg::BSL_RSVD_LAST) begin
						state_reg <= bsl_pkg::BSL_ENT_HI;
					end
				end
				bsl_pkg::BSL_ENT_HI: state_reg <= bsl_pkg::BSL_ENT_LO;
				bsl_pkg::BSL_ENT_LO: state_reg <= bsl_pkg::BSL_SIZE;
				bsl_pkg::BSL_SIZE: begin
					// zero length closes the stream; see R9
					state_reg <= (wd == bsl_pkg::BSL_END_SIZE) ? bsl_pkg::BSL_DONE
						: bsl_pkg::BSL_ADR_HI;
				end
				bsl_pkg::BSL_ADR_HI: state_reg <= bsl_pkg::BSL_ADR_LO;
				bsl_pkg::BSL_ADR_LO: state_reg <= bsl_pkg::BSL_DATA;
				bsl_pkg::BSL_DATA: begin
					// last word of the block, then the next length; see R8
					if (left_reg == 16'h0001) begin
						state_reg <= bsl_pkg::BSL_SIZE;
					end
				end
				default: state_reg <= state_reg; // idle, done, abort ignore words
			endcase
		end
	end

	// busy and status flags, kept until the next start
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			error_reg <= 1'b0;
		end else if (launch) begin
			busy_reg <= 1'b1;
			done_reg <= 1'b0;
			error_reg <= 1'b0;
		end else if (wv && state_reg == bsl_pkg::BSL_KEY && !key_ok(wd)) begin
			busy_reg <= 1'b0;
			error_reg <= 1'b1; // see R12
		end else if (wv && state_reg == bsl_pkg::BSL_SIZE && wd == bsl_pkg::BSL_END_SIZE) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b1; // see R12
		end
	end

	// reserved word counter
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rsvd_cnt_reg <= 3'h0;
		end else if (launch) begin
			rsvd_cnt_reg <= 3'h0;
		end else if (wv && state_reg == bsl_pkg::BSL_RSVD) begin
			rsvd_cnt_reg <= rsvd_cnt_reg + 3'h1; // value dropped; see R3
		end
	end

	// entry address capture and hand-over
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			entry_hi_reg <= '0;
			entry_reg <= '0;
			entry_valid_reg <= 1'b0;
		end else if (launch) begin
			entry_valid_reg <= 1'b0;
		end else if (wv) begin
			if (state_reg == bsl_pkg::BSL_ENT_HI) begin
				entry_hi_reg <= wd[bsl_pkg::BSL_ENTRY_HI_W-1:0]; // see R4
			end
			if (state_reg == bsl_pkg::BSL_ENT_LO) begin
				entry_reg <= {entry_hi_reg, wd}; // see R4 R10
			end
			if (state_reg == bsl_pkg::BSL_SIZE && wd == bsl_pkg::BSL_END_SIZE) begin
				entry_valid_reg <= 1'b1; // see R5
			end
		end
	end

	// block length and destination address
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			left_reg <= bsl_pkg::BSL_WORD_RST;
			addr_hi_reg <= bsl_pkg::BSL_WORD_RST;
			wr_addr_reg <= '0;
		end else if (wv) begin
			case (state_reg)
				bsl_pkg::BSL_SIZE: left_reg <= wd; // count of words; see R6
				bsl_pkg::BSL_ADR_HI: addr_hi_reg <= wd; // see R7
				bsl_pkg::BSL_ADR_LO: wr_addr_reg <= {addr_hi_reg, wd}; // see R7
				bsl_pkg::BSL_DATA: begin
					left_reg <= left_reg - 16'h0001; // see R8
					wr_addr_reg <= wr_addr_reg + bsl_pkg::BSL_ADDR_ONE; // see R11
				end
				default: left_reg <= left_reg;
			endcase
		end
	end

	// memory write port, one word per strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_we_reg <= 1'b0;
			mem_addr_reg <= '0;
			mem_wdata_reg <= bsl_pkg::BSL_WORD_RST;
		end else begin
			mem_we_reg <= 1'b0;
			if (wv && !launch && state_reg == bsl_pkg::BSL_DATA) begin
				mem_we_reg <= 1'b1; // see R8 R11
				mem_addr_reg <= wr_addr_reg;
				mem_wdata_reg <= wd;
			end
		end
	end

	property p_bad_key;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_KEY && !key_ok(wd))
		|=> (state_reg == bsl_pkg::BSL_ABORT && error_reg && !busy_reg);
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("bad key not aborted"); // see R2 R12

	property p_abort_quiet;
		@(posedge clock) disable iff (!reset_n)
		(state_reg == bsl_pkg::BSL_ABORT && !start) |=> (!mem_we_reg && !wif.word_valid);
	endproperty
	a_abort_quiet: assert property (p_abort_quiet) else $error("write after abort"); // see R2

	property p_good_key;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_KEY && key_ok(wd))
		|=> (state_reg == bsl_pkg::BSL_RSVD && rsvd_cnt_reg == 3'h0);
	endproperty
	a_good_key: assert property (p_good_key) else $error("valid key refused"); // see R1

	property p_rsvd_eight;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_RSVD)
		|=> (state_reg == (($past(rsvd_cnt_reg) == 3'h7) ? bsl_pkg::BSL_ENT_HI
			: bsl_pkg::BSL_RSVD)) && !mem_we_reg;
	endproperty
	a_rsvd_eight: assert property (p_rsvd_eight) else $error("reserved count wrong"); // see R3

	property p_entry;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_ENT_LO)
		|=> (entry_reg == {$past(entry_hi_reg), $past(wd)});
	endproperty
	a_entry: assert property (p_entry) else $error("entry address wrong"); // see R4

	property p_end;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_SIZE && wd == bsl_pkg::BSL_END_SIZE)
		|=> (done_reg && entry_valid_reg && state_reg == bsl_pkg::BSL_DONE && !busy_reg);
	endproperty
	a_end: assert property (p_end) else $error("end of load not flagged"); // see R5 R9 R12

	property p_size;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_SIZE && wd != bsl_pkg::BSL_END_SIZE)
		|=> (state_reg == bsl_pkg::BSL_ADR_HI && left_reg == $past(wd));
	endproperty
	a_size: assert property (p_size) else $error("block length not taken"); // see R6

	property p_dest;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_ADR_LO)
		|=> (wr_addr_reg == {addr_hi_reg, $past(wd)} && state_reg == bsl_pkg::BSL_DATA);
	endproperty
	a_dest: assert property (p_dest) else $error("destination assembled wrong"); // see R7

	property p_write;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_DATA)
		|=> (mem_we_reg && mem_wdata_reg == $past(wd) && mem_addr_reg == $past(wr_addr_reg)
			&& wr_addr_reg == $past(wr_addr_reg) + bsl_pkg::BSL_ADDR_ONE);
	endproperty
	a_write: assert property (p_write) else $error("block word not written"); // see R8 R11

	property p_block_end;
		@(posedge clock) disable iff (!reset_n)
		(wv && !launch && state_reg == bsl_pkg::BSL_DATA && left_reg == 16'h0001)
		|=> (state_reg == bsl_pkg::BSL_SIZE);
	endproperty
	a_block_end: assert property (p_block_end) else $error("block length overrun"); // see R8
endmodule
`default_nettype wire

// ---- bsl_host_model.sv ----
// host model: feeds the loader a boot stream word by word or byte by byte
`default_nettype none
module bsl_host_model (
	input wire logic clock,
	output logic in_valid,
	output logic [15:0] in_data
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap = 0; // idle cycles after each transfer, 0 = back to back
	logic byte_mode = 1'b0; // send each word as two bytes
	initial begin
		in_valid = 1'b0;
		in_data = 16'h0000;
	end
	// one transfer after a falling edge; released data is inverted, never stale
	task automatic xfer(input logic [15:0] v);
		@(negedge clock);
		in_valid = 1'b1;
		in_data = v;
		if (gap != 0) begin // slow host
			@(negedge clock);
			in_valid = 1'b0;
			in_data = ~v;
			repeat (gap - 1) @(negedge clock);
		end
	endtask
	// line goes quiet after the last transfer
	task automatic quiet();
		@(negedge clock);
		in_valid = 1'b0;
		in_data = ~in_data;
	endtask
	// one 16-bit word; byte stream sends low byte first
	task automatic word(input logic [15:0] w);
		if (byte_mode) begin
			xfer({8'h00, w[7:0]});
			xfer({8'h00, w[15:8]});
		end else begin
			xfer(w);
		end
	endtask
	// 32-bit quantity, most significant word first
	task automatic dword(input logic [31:0] v);
		word(v[31:16]);
		word(v[15:0]);
	endtask
	// key, eight throwaway words, entry address
	task automatic header(input logic [15:0] key, input logic [31:0] entry);
		word(key);
		for (int i = 0; i < 8; i++) word(16'hA5A0 + 16'(i));
		dword(entry);
	endtask
	// length in words, destination, then exactly that many words
	task automatic block(input logic [31:0] dest, input logic [15:0] n, input logic [15:0] b);
		word(n);
		dword(dest);
		for (int i = 0; i < n; i++) word(b + 16'(i));
	endtask
	// zero length closes the stream, nothing follows it
	task automatic finish_load();
		word(16'h0000);
		quiet();
	endtask
endmodule
`default_nettype wire

// ---- bsl_loader_tb_top.sv ----
// self-checking bench for the boot stream loader
`default_nettype none
module bsl_loader_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0; // 20 MHz
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic load_busy, load_done, load_error, stream_wide, entry_valid, mem_we;
	logic [bsl_pkg::BSL_ENTRY_W-1:0] entry_addr;
	logic [bsl_pkg::BSL_ADDR_W-1:0] mem_addr;
	logic [15:0] mem_wdata;
	logic in_valid;
	logic [15:0] in_data;
	int errors = 0;
	int n_compared = 0;
	logic [47:0] wr_q[$]; // writes seen, {addr, data}
	always #25 clock = ~clock;
	bsl_loader i_dut (.clock(clock), .reset_n(reset_n), .start(start), .in_valid(in_valid),
		.in_data(in_data), .load_busy(load_busy), .load_done(load_done),
		.load_error(load_error), .stream_wide(stream_wide), .entry_valid(entry_valid),
		.entry_addr(entry_addr), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	bsl_host_model i_host (.clock(clock), .in_valid(in_valid), .in_data(in_data));
	// log every one-cycle write strobe; mid-cycle sampling keeps clear of the launching edge
	always @(negedge clock) begin
		if (mem_we === 1'b1) begin
			wr_q.push_back({mem_addr, mem_wdata});
		end
	end
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// one-cycle start; busy must rise and old flags must clear
	task automatic kick();
		@(negedge clock);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		wr_q.delete();
		check(48'({load_busy, load_done, load_error, entry_valid}), 48'h8);
	endtask
	// bounded wait for the load to finish or abort
	task automatic wait_end();
		int n;
		n = 0;
		while (load_busy !== 1'b0 && n < 400) begin
			@(negedge clock);
			n++;
		end
		if (n == 400) check(48'h1, 48'h0);
		@(negedge clock);
	endtask
	// pop n logged writes and compare with successive addresses
	task automatic expect_block(input logic [31:0] dest, input int n, input logic [15:0] b);
		logic [47:0] w;
		for (int i = 0; i < n; i++) begin
			w = (wr_q.size() > 0) ? wr_q.pop_front() : 48'bx;
			check(w, {dest + 32'(i), b + 16'(i)});
		end
	endtask
	// word stream, two blocks back to back, start pulse mid-load ignored
	task automatic t_wide();
		i_host.gap = 0;
		i_host.byte_mode = 1'b0;
		kick();
		i_host.header(bsl_pkg::BSL_KEY_16BIT, 32'h003F_8000);
		i_host.block(32'h003F_9010, 16'h0005, 16'h0001);
		start = 1'b1; // refused while busy
		fork
			begin
				@(negedge clock);
				start = 1'b0;
			end
		join_none
		i_host.block(32'h003F_8000, 16'h0002, 16'h7700);
		i_host.finish_load();
		wait_end();
		expect_block(32'h003F_9010, 5, 16'h0001);
		expect_block(32'h003F_8000, 2, 16'h7700);
		check(48'(wr_q.size()), 48'h0);
		check(48'({load_busy, load_done, load_error, entry_valid, stream_wide}), 48'hB);
		check(48'(entry_addr), 48'h3F8000);
		$display("test wide stream done");
	endtask
	// slow byte stream, block that wraps the address space
	task automatic t_byte();
		i_host.gap = 2;
		i_host.byte_mode = 1'b1;
		kick();
		i_host.header(bsl_pkg::BSL_KEY_8BIT, 32'h0055_1234);
		i_host.block(32'hFFFF_FFFF, 16'h0003, 16'hBEEF);
		i_host.block(32'h0000_0100, 16'h0001, 16'h1280);
		i_host.finish_load();
		wait_end();
		expect_block(32'hFFFF_FFFF, 3, 16'hBEEF);
		expect_block(32'h0000_0100, 1, 16'h1280);
		check(48'(wr_q.size()), 48'h0);
		check(48'({load_busy, load_done, load_error, entry_valid, stream_wide}), 48'hA);
		check(48'(entry_addr), 48'h551234);
		$display("test byte stream done");
	endtask
	// bad keys in both widths: abort, nothing stored afterwards
	task automatic t_bad();
		logic [15:0] keys [2] = '{16'h10AB, 16'h09AA};
		i_host.gap = 0;
		for (int k = 0; k < 2; k++) begin
			i_host.byte_mode = k[0];
			kick();
			i_host.header(keys[k], 32'h0000_0001);
			i_host.block(32'h0000_0100, 16'h0002, 16'h1111);
			i_host.finish_load();
			wait_end();
			check(48'({load_busy, load_done, load_error, entry_valid}), 48'h2);
			check(48'(wr_q.size()), 48'h0);
		end
		$display("test bad key done");
	endtask
	// restart after abort, stream with no blocks at all
	task automatic t_empty();
		i_host.byte_mode = 1'b0;
		kick();
		i_host.header(bsl_pkg::BSL_KEY_16BIT, 32'h007F_FFFF);
		i_host.finish_load();
		wait_end();
		check(48'(wr_q.size()), 48'h0);
		check(48'({load_busy, load_done, load_error, entry_valid}), 48'h5);
		check(48'(entry_addr), 48'h7FFFFF);
		$display("test empty load done");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		@(negedge clock);
		reset_n = 1'b1;
		check(48'({load_busy, load_done, load_error, entry_valid, stream_wide, mem_we}), 48'h0);
		// a transfer while idle must be dropped, not taken as a key
		i_host.word(bsl_pkg::BSL_KEY_16BIT);
		i_host.quiet();
		check(48'({load_busy, stream_wide, mem_we}), 48'h0);
		t_wide();
		t_byte();
		t_bad();
		t_empty();
		results();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		results();
	end
endmodule
`default_nettype wire
